// >>> rtl/csf_status_regs.sv
// csf_status_regs: processor status flags with axi4-lite access and interrupt
// assumes alu and system events arrive on aclk; software on axi4-lite
//
// Notes on behaviour
// RL1: watchdog time-out event sets the timeout flag, bit 5.
// RL2: timeout flag clears on reset, watchdog-clear instruction, or halt.
// RL3: halt sets power-down flag bit 4; reset or watchdog-clear clears it.
// RL4: nibble carry set on low-nibble carry in add, or no borrow in subtract.
// RL5: rotate-through-carry instructions also update the carry flag.
// RL6: overflow set when carry into msb differs from carry out.
// RL7: zero flag set when arithmetic or logic result is zero.
// RL8: carry set on add carry or subtract without borrow.
// RL9: software writes never change the timeout or power-down flags.
// RL10: the two top status bits read zero and ignore writes.
`timescale 1ns/100ps
`default_nettype none
module csf_status_regs
    import csf_pkg::*;
(
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite write address
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [CSF_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]            s_axi_awprot,
    // axi4-lite write data
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    // axi4-lite write response
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    output logic [1:0]                 s_axi_bresp,
    // axi4-lite read address
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    input  wire logic [CSF_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]            s_axi_arprot,
    // axi4-lite read data
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    // core side
    input  wire csf_alu_t              alu,
    input  wire csf_sys_t              sys,
    output logic [7:0]                 processor_status_flags,
    output logic                       irq
);

    // ==========================================================
    // flag calculation
    csf_flags_t flags;

    csf_flag_calc u_calc (
        .alu   (alu),
        .flags (flags)
    );

    // ==========================================================
    // bus state
    logic              aw_held;
    logic              w_held;
    logic [CSF_ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              next_aw_held;
    logic              next_w_held;
    logic [CSF_ADDR_W-1:0] next_aw_addr;
    logic [31:0]       next_w_data;
    logic [3:0]        next_w_strb;
    logic              next_bvalid;
    logic [1:0]        next_bresp;
    logic              next_rvalid;
    logic [31:0]       next_rdata;
    logic [1:0]        next_rresp;
    logic              wr_fire;
    // interrupt state is read back over the bus, so it is declared here
    logic [CSF_IRQ_N-1:0] irq_status;
    logic [CSF_IRQ_N-1:0] irq_enable;

    // address and data may arrive in either order; each is held until both are in
    always_comb begin
        next_aw_held = aw_held;
        next_w_held  = w_held;
        next_aw_addr = aw_addr;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        next_rvalid  = s_axi_rvalid;
        next_rdata   = s_axi_rdata;
        next_rresp   = s_axi_rresp;
        wr_fire      = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (aw_held && w_held && !s_axi_bvalid) begin
            wr_fire      = 1'b1;
            next_aw_held = 1'b0;
            next_w_held  = 1'b0;
            next_bvalid  = 1'b1;
            next_bresp   = CSF_RESP_OKAY;
            if (aw_addr[1:0] != 2'h0 || aw_addr == CSF_ADDR_IRQ_ST) begin
                next_bresp = CSF_RESP_SLVERR;
            end
        end
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp  = CSF_RESP_OKAY;
            case (s_axi_araddr)
                CSF_ADDR_STATUS:  next_rdata = {24'h000000, processor_status_flags};
                CSF_ADDR_IRQ_ST:  next_rdata = {30'h00000000, irq_status};
                CSF_ADDR_IRQ_EN:  next_rdata = {30'h00000000, irq_enable};
                CSF_ADDR_IRQ_CLR: next_rdata = 32'h00000000;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = CSF_RESP_SLVERR;
                end
            endcase
        end
    end

    // register the bus state; ready flags are registered, one item at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= 32'h00000000;
            w_strb        <= 4'h0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= CSF_RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= CSF_RESP_OKAY;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
        end else begin
            aw_held       <= next_aw_held;
            w_held        <= next_w_held;
            aw_addr       <= next_aw_addr;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
            // drop ready the cycle after it is raised, handshake or not, so holders never overrun
            s_axi_awready <= !next_aw_held && !next_bvalid && !s_axi_awready;
            s_axi_wready  <= !next_w_held && !next_bvalid && !s_axi_wready;
            s_axi_arready <= !next_rvalid && !s_axi_arready;
        end
    end

    // ==========================================================
    // status flags
    logic [7:0]          next_status;
    logic [CSF_IRQ_N-1:0] next_irq_status;
    logic [CSF_IRQ_N-1:0] next_irq_enable;
    logic [CSF_IRQ_N-1:0] irq_event;
    logic                 sw_status_wr;

    assign sw_status_wr = wr_fire && aw_addr == CSF_ADDR_STATUS && w_strb[0];

    // software write first, then alu results override in the same cycle
    always_comb begin
        next_status = processor_status_flags;
        if (sw_status_wr) begin
            next_status = (processor_status_flags & ~CSF_SW_MASK)
                        | (w_data[7:0] & CSF_SW_MASK);               // RL9 RL10
        end
        if (flags.c_we)   next_status[CSF_BIT_C]        = flags.c;
        if (flags.nc_we)  next_status[CSF_BIT_NIBBLE]   = flags.nc;
        if (flags.z_we)   next_status[CSF_BIT_Z]        = flags.z;
        if (flags.ovf_we) next_status[CSF_BIT_OVERFLOW] = flags.ovf;
        // halt clears timeout and sets power-down; a time-out in the same
        // cycle still sets timeout so the event is not lost
        if (sys.watchdog_clear_instruction || sys.halt) begin
            next_status[CSF_BIT_TIMEOUT] = 1'b0;                     // RL2
        end
        if (sys.watchdog_clear_instruction) begin
            next_status[CSF_BIT_PD] = 1'b0;                          // RL3
        end
        if (sys.halt) begin
            next_status[CSF_BIT_PD] = 1'b1;                          // RL3
        end
        if (sys.wdt_timeout) begin
            next_status[CSF_BIT_TIMEOUT] = 1'b1;                     // RL1
        end
        next_status[7:6] = 2'h0;                                     // RL10
    end

    // ==========================================================
    // interrupt: sticky on time-out and halt; set wins over clear
    always_comb begin
        irq_event              = '0;
        irq_event[CSF_IRQ_TIMEOUT] = sys.wdt_timeout;
        irq_event[CSF_IRQ_PD]      = sys.halt;
        next_irq_status = irq_status;
        next_irq_enable = irq_enable;
        if (wr_fire && aw_addr == CSF_ADDR_IRQ_CLR && w_strb[0]) begin
            next_irq_status = irq_status & ~w_data[CSF_IRQ_N-1:0];
        end
        if (wr_fire && aw_addr == CSF_ADDR_IRQ_EN && w_strb[0]) begin
            next_irq_enable = w_data[CSF_IRQ_N-1:0];
        end
        next_irq_status = next_irq_status | irq_event;
    end

    // power-up reset clears every flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            processor_status_flags <= CSF_STAT_RESET;                // RL2 RL3
            irq_status             <= '0;
            irq_enable             <= '0;
            irq                    <= 1'b0;
        end else begin
            processor_status_flags <= next_status;
            irq_status             <= next_irq_status;
            irq_enable             <= next_irq_enable;
            irq                    <= |(next_irq_status & next_irq_enable);
        end
    end

endmodule
`default_nettype wire

// >>> rtl/csf_pkg.sv
// csf_pkg: constants, register map and carrier types for the status flag block
// assumes a 32-bit axi4-lite register bus and an 8-bit alu beside the block
package csf_pkg;

    // ==========================================================
    // register map
    localparam logic [3:0] CSF_ADDR_STATUS  = 4'h0;
    localparam logic [3:0] CSF_ADDR_IRQ_ST  = 4'h4;
    localparam logic [3:0] CSF_ADDR_IRQ_EN  = 4'h8;
    localparam logic [3:0] CSF_ADDR_IRQ_CLR = 4'hC;
    localparam int         CSF_ADDR_W       = 4;

    // ==========================================================
    // status bit positions
    localparam int CSF_BIT_C        = 0;
    localparam int CSF_BIT_NIBBLE   = 1;
    localparam int CSF_BIT_Z        = 2;
    localparam int CSF_BIT_OVERFLOW = 3;
    localparam int CSF_BIT_PD       = 4;
    localparam int CSF_BIT_TIMEOUT  = 5;

    // software-writable flags: overflow, zero, nibble carry, carry
    localparam logic [7:0] CSF_SW_MASK    = 8'h0F;
    localparam logic [7:0] CSF_STAT_RESET = 8'h00;

    // interrupt status bits
    localparam int CSF_IRQ_TIMEOUT = 0;
    localparam int CSF_IRQ_PD      = 1;
    localparam int CSF_IRQ_N       = 2;

    localparam logic [1:0] CSF_RESP_OKAY   = 2'h0;
    localparam logic [1:0] CSF_RESP_SLVERR = 2'h2;

    // ==========================================================
    // alu operation kinds
    typedef enum logic [2:0] {
        CSF_OP_NONE,
        CSF_OP_ADD,
        CSF_OP_SUB,
        CSF_OP_LOGIC,
        CSF_OP_RLC,
        CSF_OP_RRC
    } csf_op_t;

    // one alu result, presented for one cycle with valid
    typedef struct packed {
        logic       valid;
        csf_op_t    op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] result;
    } csf_alu_t;

    // system events, one-cycle pulses
    typedef struct packed {
        logic wdt_timeout;
        logic halt;
        logic watchdog_clear_instruction;
    } csf_sys_t;

    // flags that an alu operation produces
    typedef struct packed {
        logic ovf_we;
        logic ovf;
        logic z_we;
        logic z;
        logic nc_we;
        logic nc;
        logic c_we;
        logic c;
    } csf_flags_t;

endpackage

// >>> rtl/csf_flag_calc.sv
// csf_flag_calc: derives arithmetic flags from one alu operation
// assumes operands and result are valid in the same cycle; purely combinational
`timescale 1ns/100ps
`default_nettype none
module csf_flag_calc
    import csf_pkg::*;
(
    // alu side
    input  wire csf_alu_t   alu,
    // flag results
    output var  csf_flags_t flags
);

    // ==========================================================
    // flag arithmetic
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] low7;
    logic       c_in_msb;

    // subtraction is a + ~b + 1, so carry out means no borrow
    always_comb begin
        flags    = '0;
        sum      = 9'h000;
        nib      = 5'h00;
        low7     = 8'h00;
        c_in_msb = 1'b0;
        if (alu.valid) begin
            case (alu.op)
                CSF_OP_ADD, CSF_OP_SUB: begin
                    if (alu.op == CSF_OP_ADD) begin
                        sum  = {1'b0, alu.a} + {1'b0, alu.b};
                        nib  = {1'b0, alu.a[3:0]} + {1'b0, alu.b[3:0]};
                        low7 = {1'b0, alu.a[6:0]} + {1'b0, alu.b[6:0]};
                    end else begin
                        sum  = {1'b0, alu.a} + {1'b0, ~alu.b} + 9'h001;
                        nib  = {1'b0, alu.a[3:0]} + {1'b0, ~alu.b[3:0]} + 5'h01;
                        low7 = {1'b0, alu.a[6:0]} + {1'b0, ~alu.b[6:0]} + 8'h01;
                    end
                    c_in_msb    = low7[7];
                    flags.c_we   = 1'b1;
                    flags.c      = sum[8];                      // RL8
                    flags.nc_we  = 1'b1;
                    flags.nc     = nib[4];                      // RL4
                    flags.ovf_we = 1'b1;
                    flags.ovf    = c_in_msb ^ sum[8];           // RL6
                    flags.z_we   = 1'b1;
                    flags.z      = (alu.result == 8'h00);       // RL7
                end
                CSF_OP_LOGIC: begin
                    flags.z_we = 1'b1;
                    flags.z    = (alu.result == 8'h00);         // RL7
                end
                CSF_OP_RLC: begin
                    flags.c_we = 1'b1;
                    flags.c    = alu.a[7];                      // RL5
                end
                CSF_OP_RRC: begin
                    flags.c_we = 1'b1;
                    flags.c    = alu.a[0];                      // RL5
                end
                default: begin
                    flags = '0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

// >>> verif/csf_status_regs_asserts.sv
// csf_status_regs_asserts: port-level timing checks for the status flag block
// assumes it is bound into csf_status_regs; one aclk domain, sync active-low reset
`timescale 1ns/100ps
`default_nettype none
module csf_status_regs_asserts
    import csf_pkg::*;
(
    // clock and reset
    input wire logic       aclk,
    input wire logic       aresetn,
    // core side
    input wire csf_alu_t   alu,
    input wire csf_sys_t   sys,
    input wire logic [7:0] processor_status_flags
);
    // ==========================================================
    // reference arithmetic: subtract is a plus inverted b plus one,
    // so carry and nibble carry read as no-borrow there
    wire logic       sub = alu.op == CSF_OP_SUB;
    wire logic [7:0] bb  = sub ? ~alu.b : alu.b;
    wire logic [8:0] sm  = {1'b0, alu.a} + {1'b0, bb} + {8'h00, sub};
    wire logic [4:0] ns  = {1'b0, alu.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub};
    wire logic       ar  = alu.valid && (sub || alu.op == CSF_OP_ADD);
    wire logic       rt  = alu.valid && alu.op inside {CSF_OP_RLC, CSF_OP_RRC};
    wire logic       rot = (alu.op == CSF_OP_RLC) ? alu.a[7] : alu.a[0];
    wire logic       ovf = (alu.a[7] == bb[7]) && (sm[7] != alu.a[7]);
    wire logic       cy  = sm[8];
    wire logic       nc  = ns[4];
    wire logic       zr  = alu.result == 8'h00;
    wire logic [7:0] pf  = processor_status_flags;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ==========================================================
    // flags follow their causes one edge later
    a_timeout_set: assert property (sys.wdt_timeout |=> pf[5])
        else $error("timeout flag not set");
    a_timeout_clear: assert property (
        (sys.halt || sys.watchdog_clear_instruction) && !sys.wdt_timeout |=> !pf[5])
        else $error("timeout flag not cleared");
    a_pd_follow: assert property (
        sys.halt || sys.watchdog_clear_instruction |=> pf[4] == $past(sys.halt))
        else $error("power-down flag wrong");
    a_nibble_carry: assert property (ar |=> pf[1] == $past(nc))
        else $error("nibble carry wrong");
    a_rotate_carry: assert property (rt |=> pf[0] == $past(rot))
        else $error("rotate carry wrong");
    a_overflow: assert property (ar |=> pf[3] == $past(ovf))
        else $error("overflow wrong");
    a_zero_flag: assert property (
        alu.valid && alu.op inside {CSF_OP_ADD, CSF_OP_SUB, CSF_OP_LOGIC} |=> pf[2] == $past(zr))
        else $error("zero flag wrong");
    a_arith_carry: assert property (ar |=> pf[0] == $past(cy))
        else $error("carry wrong");
    // software cannot touch the system flags, only events can
    a_sys_hold: assert property (!(|sys) |=> $stable(pf[5:4]))
        else $error("system flags moved without event");
    a_top_zero: assert property (pf[7:6] == 2'h0)
        else $error("top bits not zero");
endmodule

bind csf_status_regs csf_status_regs_asserts u_asserts (
    .aclk(aclk),
    .aresetn(aresetn),
    .alu(alu),
    .sys(sys),
    .processor_status_flags(processor_status_flags)
);
`default_nettype wire

// >>> verif/csf_status_regs_test.sv
// csf_status_regs_test: self-checking bench for the status flag block
// assumes csf_pkg, the design and the checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module csf_status_regs_test
    import csf_pkg::*;
;
    logic        aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, irq;
    logic [3:0]  awa, ara, ws;
    logic [31:0] wd, rdat, rdv, x;
    logic [1:0]  bresp, rresp, rsp, ist, ien;
    logic [7:0]  pf, m;
    csf_alu_t    alu;
    csf_sys_t    sys;
    int          num_errors, num_checks;
    // event table: {time-out, halt, watchdog clear}
    logic [2:0]  evt [7] = '{3'h4, 3'h2, 3'h1, 3'h3, 3'h6, 3'h5, 3'h1};

    csf_status_regs DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_awprot(3'h0),
        .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
        .s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .alu(alu), .sys(sys), .processor_status_flags(pf), .irq(irq)
    );

    // ==========================================================
    // 250 MHz clock
    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========================================================
    // bus master: each channel dropped at its own handshake, no latency assumed
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge aclk);
        {awv, wv, br} <= 3'h7;
        {awa, wd, ws} <= {a, d, s};
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
        end while (!bv);
        rsp = bresp;
        br <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge aclk);
        {arv, rr} <= 2'h3;
        ara <= a;
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rdv = rdat;
        rsp = rresp;
        rr <= 1'b0;
    endtask

    // one alu pulse; the model flags are worked out after the edge that registers it
    task automatic op(input csf_op_t o, input logic [7:0] a, input logic [7:0] b);
        logic       s;
        logic [7:0] bb, r;
        logic [8:0] sm;
        s = (o == CSF_OP_SUB);
        bb = s ? ~b : b;
        sm = {1'b0, a} + {1'b0, bb} + {8'h00, s};
        r = (o == CSF_OP_LOGIC) ? (a ^ b) : sm[7:0];
        if (o == CSF_OP_RLC) r = {a[6:0], m[0]};
        if (o == CSF_OP_RRC) r = {m[0], a[7:1]};
        @(posedge aclk);
        alu <= '{1'b1, o, a, b, r};
        @(posedge aclk);
        alu.valid <= 1'b0;
        if (o == CSF_OP_ADD || s) begin
            m[0] = sm[8];
            m[1] = ({1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, s}) > 5'h0F;
            m[3] = (a[7] == bb[7]) && (sm[7] != a[7]);
        end
        if (o == CSF_OP_RLC || o == CSF_OP_RRC) m[0] = (o == CSF_OP_RLC) ? a[7] : a[0];
        else m[2] = (r == 8'h00);
        #1;
        chk("flags", {24'h0, pf}, {24'h0, m});
    endtask

    // one system pulse; clear applies first, then halt, time-out set wins
    task automatic ev(input logic [2:0] v);
        @(posedge aclk);
        sys <= csf_sys_t'(v);
        @(posedge aclk);
        sys <= csf_sys_t'(3'h0);
        if (v[0]) m[5:4] = 2'h0;
        if (v[1]) m[5:4] = 2'h1;
        if (v[2]) m[5] = 1'b1;
        ist = ist | {v[1], v[2]};
        #1;
        chk("sys", {24'h0, pf}, {24'h0, m});
        chk("irq", {31'h0, irq}, {31'h0, |(ist & ien)});
    endtask

    // ==========================================================
    // watchdog: the whole run needs well under this many cycles
    initial begin
        repeat (8000) @(posedge aclk);
        num_errors++;
        stop_test();
    end

    initial begin
        {aresetn, awv, wv, br, arv, rr} = 6'h0;
        {awa, ara, ws, wd} = 44'h0;
        alu = '0;
        sys = '0;
        {num_errors, num_checks} = 64'h0;
        m = CSF_STAT_RESET;
        {ist, ien} = 4'h0;
        x = 32'hBD609A78;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(CSF_ADDR_STATUS);
        chk("st_rst", rdv, {24'h0, CSF_STAT_RESET});
        wr(CSF_ADDR_IRQ_EN, 32'h3, 4'hF);
        ien = 2'h3;
        foreach (evt[i]) ev(evt[i]);
        rd(CSF_ADDR_IRQ_ST);
        chk("ist", rdv, {30'h0, ist});
        wr(CSF_ADDR_IRQ_CLR, 32'h3, 4'hF);
        wr(CSF_ADDR_IRQ_EN, 32'h1, 4'hF);
        ist = 2'h0;
        ien = 2'h1;
        ev(3'h2);
        wr(CSF_ADDR_IRQ_EN, 32'h3, 4'hF);
        rd(CSF_ADDR_IRQ_ST);
        chk("ist_mask", rdv, 32'h2);
        chk("irq_en", {31'h0, irq}, 32'h1);
        // a strobe-off write is sent but its effect is never checked, then the system bits must survive writes
        wr(CSF_ADDR_STATUS, 32'hFFFFFFFF, 4'h0);
        wr(CSF_ADDR_STATUS, 32'hFFFFFFFF, 4'hF);
        chk("wr_ok", {30'h0, rsp}, {30'h0, CSF_RESP_OKAY});
        m[3:0] = 4'hF;
        rd(CSF_ADDR_STATUS);
        chk("sw_set", rdv, {24'h0, m});
        wr(CSF_ADDR_STATUS, 32'h0, 4'hF);
        m[3:0] = 4'h0;
        rd(CSF_ADDR_STATUS);
        chk("sw_clr", rdv, {24'h0, m});
        rd(4'h2);
        chk("bad_rd", {30'h0, rsp}, {30'h0, CSF_RESP_SLVERR});
        wr(CSF_ADDR_IRQ_ST, 32'h0, 4'hF);
        chk("ro_wr", {30'h0, rsp}, {30'h0, CSF_RESP_SLVERR});
        op(CSF_OP_ADD, 8'h80, 8'h80);
        op(CSF_OP_SUB, 8'h3C, 8'h3C);
        op(CSF_OP_SUB, 8'h10, 8'h01);
        repeat (300) begin
            x = lfsr(x);
            op(csf_op_t'(3'(x[7:0] % 5 + 1)), x[15:8], x[23:16]);
        end
        stop_test();
    end
endmodule
`default_nettype wire
